/* bench/host_model.sv */
// Purpose: host socket model driving the register port
// Assumes: strobes change just after a rising MCLK edge
// Notes: read data taken 1ns after the edge that answers
module host_model (
  input wire logic MCLK,
  output logic [mfc_cfg_pkg::ADDR_W-1:0] ADDR,
  output logic [7:0] WDATA,
  output logic WR,
  output logic RD,
  input wire logic [7:0] RDATA
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    ADDR = '0;
    WDATA = 8'h00;
    WR = 1'b0;
    RD = 1'b0;
  end
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge MCLK);
    ADDR <= a;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge MCLK);
    WR <= 1'b0;
  endtask : wr
  // data stands one cycle only, so sample just after it lands
  task automatic rd(input logic [4:0] a, output logic [7:0] d);
    @(posedge MCLK);
    ADDR <= a;
    RD <= 1'b1;
    @(posedge MCLK);
    RD <= 1'b0;
    #1 d = RDATA;
  endtask : rd
endmodule : host_model

/* bench/multifunction_card_config_irq_share_tb.sv */
// Purpose: self-checking bench for the configuration bank
// Assumes: two functions, slot map of the package
// Notes: decode and option values drawn at random
module multifunction_card_config_irq_share_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import mfc_cfg_pkg::*;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  logic [ADDR_W-1:0] addr;
  logic [7:0] wdata, rdata, rv, d;
  logic wr, rd, ireq;
  logic [NUM_FUNC-1:0] ev = '0, svc = '0, fen, fsel;
  logic [15:0] io = 16'h0000;
  int err_count = 0, check_count = 0, cyc = 0, seed = 32'haffc;
  always #20 mclk = ~mclk;
  host_model i_host_model(.MCLK(mclk), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
    .RDATA(rdata));
  mfc_cfg_bank i_mfc_cfg_bank(.MCLK(mclk), .RST_N(rst_n), .ADDR(addr), .WDATA(wdata),
    .WR(wr), .RD(rd), .RDATA(rdata), .FUNC_EVENT(ev), .FUNC_SERVICED(svc), .IO_ADDR(io),
    .FUNC_ENABLE(fen), .FUNC_SELECT(fsel), .IREQ(ireq));
  task automatic final_report;
    if (err_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    check_count++;
    if (s !== e) begin
      err_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  // limit fills downward, range stays a power of two
  function automatic logic [7:0] fill(input logic [7:0] v);
    for (int i = 6; i >= 0; i--) v[i] = v[i] | v[i+1];
    return v;
  endfunction : fill
  task automatic pulse(input logic [1:0] e, input logic [1:0] s);
    @(posedge mclk);
    ev <= e;
    svc <= s;
    @(posedge mclk);
    ev <= '0;
    svc <= '0;
    @(posedge mclk);
    #1;
  endtask : pulse
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end
  initial begin
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    for (int a = 0; a < 17; a++) begin
      i_host_model.rd(a[4:0], rv);
      chk(rv, (a[2:0] == OFS_PRESENCE) ? PRESENCE_MASK : 8'h00);
    end
    for (int i = 0; i < 20; i++) begin
      d = 8'($random(seed));
      i_host_model.wr({1'b0, i[0], OFS_OPTION}, d);
      #1 chk(fen[i[0]], d[0]);
      i_host_model.rd({1'b0, i[0], OFS_OPTION}, rv);
      chk(rv, d & OPTION_MASK);
    end
    // bases loaded before the function is enabled
    i_host_model.wr(5'h02, 8'h40);
    i_host_model.wr(5'h03, 8'h12);
    i_host_model.wr(5'h06, 8'h04);
    i_host_model.rd(5'h06, rv);
    chk(rv, fill(8'h04));
    i_host_model.wr(5'h00, 8'h03);
    for (int i = 0; i < 30; i++) begin
      @(posedge mclk);
      io <= 16'h1240 ^ (16'($random(seed)) & 16'h010F);
      @(posedge mclk);
      chk(fsel[0], (io & ~{8'h00, fill(8'h04)}) == 16'h1240);
    end
    io <= 16'h1241;
    i_host_model.wr(5'h00, 8'h01);
    #1 chk(fsel[0], 1'b0);
    i_host_model.wr(5'h00, 8'h02);
    #1 chk(fsel[0], 1'b0);
    i_host_model.wr(5'h00, 8'h07);
    i_host_model.wr(5'h08, 8'h07);
    io <= 16'h0000;
    @(posedge mclk);
    #1 chk(fsel[1], 1'b1);
    chk(fsel[0], 1'b0);
    pulse(2'b01, 2'b00);
    chk(ireq, 1'b1);
    i_host_model.rd(5'h09, rv);
    chk(rv, 8'h02);
    pulse(2'b00, 2'b01);
    chk(ireq, 1'b0);
    i_host_model.wr(5'h01, 8'h01);
    pulse(2'b01, 2'b00);
    pulse(2'b00, 2'b01);
    chk(ireq, 1'b1);
    i_host_model.rd(5'h01, rv);
    chk(rv, 8'h03);
    pulse(2'b10, 2'b00);
    // host acknowledge: zero written to pending
    i_host_model.wr(5'h01, 8'h01);
    #1 chk(ireq, 1'b1);
    i_host_model.rd(5'h01, rv);
    chk(rv, 8'h01);
    pulse(2'b00, 2'b10);
    chk(ireq, 1'b0);
    i_host_model.wr(5'h08, 8'h03);
    pulse(2'b10, 2'b00);
    chk(ireq, 1'b0);
    final_report();
  end
endmodule : multifunction_card_config_irq_share_tb

/* pkg/mfc_cfg_pkg.sv */
// Purpose: constants for the multifunction card configuration bank
// Assumes: two functions, byte-wide registers, one word per register
// Notes: register index = function * 8 + slot
//
// Summary of operation
// (RQ1) option bit 0 enables its function
// (RQ2) option bit 1 enables base/limit decode
// (RQ3) option bit 2 routes interrupts to line
// (RQ4) option bits 3-5 vendor defined, plain storage
// (RQ5) status bit 0 ack mode, bit 1 pending
// (RQ6) ack mode 0 means legacy interrupt signalling
// (RQ7) legacy: function clears pending when serviced
// (RQ8) ack mode 1: host acknowledge before renotify
// (RQ9) host writes 0 to pending when done
// (RQ10) after clear, renotify if any request remains
// (RQ11) pending flag aliased across legacy-mode functions; code ORs in only the routed ones
// (RQ12) four base registers and one limit each
// (RQ13) host loads bases before enabling function
// (RQ14) limit bits contiguous, power-of-two ranges
// (RQ15) absent base registers shown in presence mask
// (RQ16) at least two bases cover 64 KByte
// (RQ17) limit register optional when width fixed
// (RQ18) host runs handlers, EOI once, clears pending
// (RQ19) separate secondary structure per function
// (RQ20) each function has its own register set
// (RQ21) line is OR of routed pending requests
// (RQ22) decode hit when masked address equals base
package mfc_cfg_pkg;
  localparam int NUM_FUNC = 2;
  localparam int NUM_BASE = 4;
  localparam int ADDR_W = 5;
  localparam int IO_ADDR_W = 16;
  localparam logic [2:0] OFS_OPTION = 3'h0;
  localparam logic [2:0] OFS_STATUS = 3'h1;
  localparam logic [2:0] OFS_BASE0 = 3'h2;
  localparam logic [2:0] OFS_LIMIT = 3'h6;
  localparam logic [2:0] OFS_PRESENCE = 3'h7;
  localparam int OPT_ENABLE = 0;
  localparam int OPT_DECODE = 1;
  localparam int OPT_ROUTE = 2;
  localparam int STS_ACK_MODE = 0;
  localparam int STS_PENDING = 1;
  localparam logic [7:0] OPTION_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET = 8'h00;
  localparam logic [7:0] BASE_RESET = 8'h00;
  localparam logic [7:0] LIMIT_RESET = 8'h00;
  localparam logic [7:0] OPTION_MASK = 8'h3F;
  localparam logic [7:0] PRESENCE_MASK = 8'h0F;
endpackage : mfc_cfg_pkg

/* verilog/mfc_cfg_bank.sv */
// Purpose: per-function option, status, base and limit registers with shared irq line
// Assumes: inputs synchronous to MCLK; host clears pending by writing status
// Notes: address bit 3 selects function, bits 2:0 select the register slot
module mfc_cfg_bank (
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic [mfc_cfg_pkg::ADDR_W-1:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic [mfc_cfg_pkg::NUM_FUNC-1:0] FUNC_EVENT,
  input wire logic [mfc_cfg_pkg::NUM_FUNC-1:0] FUNC_SERVICED,
  input wire logic [15:0] IO_ADDR,
  output logic [mfc_cfg_pkg::NUM_FUNC-1:0] FUNC_ENABLE,
  output logic [mfc_cfg_pkg::NUM_FUNC-1:0] FUNC_SELECT,
  output logic IREQ
);
  import mfc_cfg_pkg::*;

  logic [7:0] option [NUM_FUNC];
  logic [7:0] ack_mode_reg [NUM_FUNC];
  logic [7:0] io_base [NUM_FUNC][NUM_BASE];
  logic [7:0] io_limit [NUM_FUNC];
  logic [NUM_FUNC-1:0] pending;
  logic [NUM_FUNC-1:0] interrupt_ack_mode;
  logic [NUM_FUNC-1:0] routed;
  logic [NUM_FUNC-1:0] status_clear;
  logic legacy_pending;
  logic [7:0] next_rdata;

  function automatic logic hit(input logic [4:0] a, input int f, input logic [2:0] slot);
    hit = (a[4:3] == 2'(f)) && (a[2:0] == slot);
  endfunction : hit

  assign legacy_pending = |(pending & ~interrupt_ack_mode & routed);

  genvar g;
  generate
    for (g = 0; g < NUM_FUNC; g++) begin : gen_func
      assign interrupt_ack_mode[g] = ack_mode_reg[g][STS_ACK_MODE];
      assign routed[g] = option[g][OPT_ROUTE];
      assign status_clear[g] = WR && hit(ADDR, g, OFS_STATUS) && !WDATA[STS_PENDING];

      // (RQ1) own enable bit, (RQ4) vendor bits kept
      always_ff @(posedge MCLK) begin
        if (!RST_N) begin
          option[g] <= OPTION_RESET;
        end else if (WR && hit(ADDR, g, OFS_OPTION)) begin
          option[g] <= WDATA & OPTION_MASK;
        end
      end

      // (RQ5) ack mode held in bit 0
      always_ff @(posedge MCLK) begin
        if (!RST_N) begin
          ack_mode_reg[g] <= STATUS_RESET;
        end else if (WR && hit(ADDR, g, OFS_STATUS)) begin
          ack_mode_reg[g] <= {7'h00, WDATA[STS_ACK_MODE]};
        end
      end

      // (RQ6) (RQ7) legacy clear by function; (RQ8) ack mode needs host clear
      // (RQ10) event beats clear so request renotifies
      always_ff @(posedge MCLK) begin
        if (!RST_N) begin
          pending[g] <= 1'b0;
        end else if (FUNC_EVENT[g]) begin
          pending[g] <= 1'b1;
        end else if (!interrupt_ack_mode[g] && FUNC_SERVICED[g]) begin
          pending[g] <= 1'b0;
        end else if (status_clear[g]) begin
          pending[g] <= 1'b0;
        end
      end

      // (RQ12) four bases and a limit; (RQ20) per function
      for (genvar b = 0; b < NUM_BASE; b++) begin : gen_base
        always_ff @(posedge MCLK) begin
          if (!RST_N) begin
            io_base[g][b] <= BASE_RESET;
          end else if (WR && hit(ADDR, g, OFS_BASE0 + 3'(b))) begin
            io_base[g][b] <= WDATA;
          end
        end

        // (RQ12) base write lands
        base_write_a: assert property (@(posedge MCLK) disable iff (!RST_N)
          (WR && hit(ADDR, g, OFS_BASE0 + 3'(b)))
          |=> io_base[g][b] == $past(WDATA))
          else $error("base write lost");

        // (RQ20) base untouched by other accesses
        base_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N)
          !(WR && hit(ADDR, g, OFS_BASE0 + 3'(b)))
          |=> $stable(io_base[g][b]))
          else $error("base changed unasked");

        // (RQ12) base reads back
        base_read_a: assert property (@(posedge MCLK) disable iff (!RST_N)
          (RD && hit(ADDR, g, OFS_BASE0 + 3'(b)))
          |=> RDATA == $past(io_base[g][b]))
          else $error("base read wrong");
      end

      // (RQ17) limit present in every configuration
      // (RQ14) limit kept contiguous: fill below top set bit
      always_ff @(posedge MCLK) begin
        if (!RST_N) begin
          io_limit[g] <= LIMIT_RESET;
        end else if (WR && hit(ADDR, g, OFS_LIMIT)) begin
          io_limit[g] <= WDATA | (WDATA >> 1) | (WDATA >> 2) | (WDATA >> 3)
            | (WDATA >> 4) | (WDATA >> 5) | (WDATA >> 6) | (WDATA >> 7);
        end
      end

      // (RQ22) masked compare; (RQ2) decode only with bit 1
      assign FUNC_SELECT[g] = option[g][OPT_ENABLE] && option[g][OPT_DECODE]
        && ((IO_ADDR & ~{8'h00, io_limit[g]})
          == ({io_base[g][1], io_base[g][0]} & ~{8'h00, io_limit[g]}));
      assign FUNC_ENABLE[g] = option[g][OPT_ENABLE];

      // checks below repeat for every function
      // (RQ4) option write keeps six low bits
      opt_write_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (WR && hit(ADDR, g, OFS_OPTION))
        |=> option[g] == ($past(WDATA) & OPTION_MASK))
        else $error("option write lost");

      // (RQ1) enable output follows bit 0
      opt_enable_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (WR && hit(ADDR, g, OFS_OPTION))
        |=> FUNC_ENABLE[g] == $past(WDATA[OPT_ENABLE]))
        else $error("enable not written");

      // (RQ20) option untouched by other accesses
      opt_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        !(WR && hit(ADDR, g, OFS_OPTION))
        |=> $stable(option[g]))
        else $error("option changed unasked");

      // (RQ4) bits above vendor field stay zero
      vendor_top_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (option[g] & ~OPTION_MASK) == 8'h00)
        else $error("option top bits set");

      // (RQ5) ack mode write lands
      ack_write_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (WR && hit(ADDR, g, OFS_STATUS))
        |=> interrupt_ack_mode[g] == $past(WDATA[STS_ACK_MODE]))
        else $error("ack mode write lost");

      // (RQ20) ack mode untouched by other accesses
      status_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        !(WR && hit(ADDR, g, OFS_STATUS))
        |=> $stable(interrupt_ack_mode[g]))
        else $error("ack mode changed unasked");

      // (RQ10) event always raises pending
      event_set_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        FUNC_EVENT[g]
        |=> pending[g])
        else $error("event not latched");

      // (RQ6) pending rises only on an event
      no_event_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (!pending[g] && !FUNC_EVENT[g])
        |=> !pending[g])
        else $error("pending without event");

      // (RQ8) host zero write clears pending
      host_clear_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (WR && hit(ADDR, g, OFS_STATUS) && !WDATA[STS_PENDING] && !FUNC_EVENT[g])
        |=> !pending[g])
        else $error("host clear ignored");

      // (RQ5) writing one leaves pending alone
      write_one_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (pending[g] && interrupt_ack_mode[g] && WR && hit(ADDR, g, OFS_STATUS)
          && WDATA[STS_PENDING])
        |=> pending[g])
        else $error("pending lost on write one");

      // (RQ8) service alone cannot end ack-mode request
      ack_service_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (pending[g] && interrupt_ack_mode[g] && FUNC_SERVICED[g] && !WR)
        |=> pending[g])
        else $error("ack pending dropped by service");

      // (RQ7) legacy service clears pending
      legacy_svc_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (!interrupt_ack_mode[g] && FUNC_SERVICED[g] && !FUNC_EVENT[g])
        |=> !pending[g])
        else $error("legacy service ignored");

      // (RQ21) routed event reaches the line
      route_event_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (FUNC_EVENT[g] && routed[g] && !WR)
        |=> IREQ)
        else $error("routed event missing on line");

      // (RQ14) every written limit bit kept
      limit_keep_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (WR && hit(ADDR, g, OFS_LIMIT))
        |=> (io_limit[g] & $past(WDATA)) == $past(WDATA))
        else $error("limit bit dropped");

      // (RQ14) range always a power of two
      limit_fill_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (io_limit[g] & (io_limit[g] + 8'h01)) == 8'h00)
        else $error("limit has a gap");

      // (RQ20) limit untouched by other accesses
      limit_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        !(WR && hit(ADDR, g, OFS_LIMIT))
        |=> $stable(io_limit[g]))
        else $error("limit changed unasked");

      // (RQ22) exact base address always hits
      select_exact_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (option[g][OPT_ENABLE] && option[g][OPT_DECODE]
          && IO_ADDR == {io_base[g][1], io_base[g][0]})
        |-> FUNC_SELECT[g])
        else $error("base address missed");

      // (RQ22) limit never masks upper lines
      select_high_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        FUNC_SELECT[g]
        |-> IO_ADDR[15:8] == io_base[g][1])
        else $error("upper address ignored");

      // (RQ2) decode needs enable and bit 1
      select_gate_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (!FUNC_ENABLE[g] || !option[g][OPT_DECODE])
        |-> !FUNC_SELECT[g])
        else $error("select without decode enable");

      // (RQ4) option reads back
      opt_read_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (RD && hit(ADDR, g, OFS_OPTION))
        |=> RDATA == $past(option[g]))
        else $error("option read wrong");

      // (RQ5) ack-mode function shows own pending
      ack_view_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (RD && hit(ADDR, g, OFS_STATUS) && interrupt_ack_mode[g])
        |=> RDATA[STS_PENDING] == $past(pending[g]))
        else $error("own pending not shown");

      // (RQ11) legacy function sees the other's request
      alias_view_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (RD && hit(ADDR, g, OFS_STATUS) && !interrupt_ack_mode[g]
          && !interrupt_ack_mode[1-g] && pending[1-g] && routed[1-g])
        |=> RDATA[STS_PENDING])
        else $error("aliased pending not shown");

      // (RQ5) ack mode reads back in bit 0
      status_mode_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (RD && hit(ADDR, g, OFS_STATUS))
        |=> RDATA[STS_ACK_MODE] == $past(interrupt_ack_mode[g]))
        else $error("ack mode read wrong");

      // (RQ14) limit reads back filled
      limit_read_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (RD && hit(ADDR, g, OFS_LIMIT))
        |=> RDATA == $past(io_limit[g]))
        else $error("limit read wrong");

      // (RQ15) presence mask reads constant
      presence_read_a: assert property (@(posedge MCLK) disable iff (!RST_N)
        (RD && hit(ADDR, g, OFS_PRESENCE))
        |=> RDATA == PRESENCE_MASK)
        else $error("presence read wrong");
    end
  endgenerate

  // (RQ3) (RQ21) line is OR of routed pending
  assign IREQ = |(pending & routed);

  // read mux, one cycle latency; unmapped slots read zero
  always_comb begin
    next_rdata = 8'h00;
    for (int f = 0; f < NUM_FUNC; f++) begin
      if (hit(ADDR, f, OFS_OPTION)) begin
        next_rdata = option[f];
      end else if (hit(ADDR, f, OFS_STATUS)) begin
        // (RQ11) legacy functions see aliased pending
        next_rdata = {6'h00,
          interrupt_ack_mode[f] ? pending[f] : legacy_pending, interrupt_ack_mode[f]};
      end else if (hit(ADDR, f, OFS_LIMIT)) begin
        next_rdata = io_limit[f];
      end else if (hit(ADDR, f, OFS_PRESENCE)) begin
        // (RQ15) (RQ16) (RQ19) presence of all bases reported
        next_rdata = PRESENCE_MASK;
      end else begin
        for (int b = 0; b < NUM_BASE; b++) begin
          if (hit(ADDR, f, OFS_BASE0 + 3'(b))) begin
            next_rdata = io_base[f][b];
          end
        end
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (!RST_N) begin
      RDATA <= 8'h00;
    end else begin
      RDATA <= RD ? next_rdata : 8'h00;
    end
  end

  // (RQ21) line follows routed pending
  irq_or_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    IREQ == |(pending & routed)) else $error("irq line mismatch");

  // (RQ8) ack-mode pending survives service strobe
  ack_hold_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (pending[0] && interrupt_ack_mode[0] && !status_clear[0])
      |=> pending[0]) else $error("ack mode pending lost");

  // (RQ7) legacy service clears pending
  legacy_clear_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (!interrupt_ack_mode[0] && FUNC_SERVICED[0] && !FUNC_EVENT[0])
      |=> !pending[0]) else $error("legacy clear failed");

  // (RQ10) event wins over host clear
  event_wins_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (FUNC_EVENT[1] && status_clear[1]) |=> pending[1]) else $error("event lost");

  // (RQ1) disabled function never selected
  enable_gate_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    !option[0][OPT_ENABLE] |-> !FUNC_SELECT[0]) else $error("select while disabled");

  // (RQ2) no decode without bit 1
  decode_gate_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    !option[1][OPT_DECODE] |-> !FUNC_SELECT[1]) else $error("decode without enable");

  // (RQ3) unrouted function never drives line
  route_gate_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (!routed[0] && !(pending[1] && routed[1])) |-> !IREQ) else $error("unrouted irq");

  // (RQ14) limit stays contiguous
  limit_shape_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    ((io_limit[0] & (io_limit[0] + 8'h01)) == 8'h00)) else $error("limit not contiguous");

  // (RQ5) status read returns ack mode in bit 0
  status_read_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (RD && hit(ADDR, 0, OFS_STATUS)) |=> RDATA[0] == $past(interrupt_ack_mode[0]))
    else $error("status read wrong");

  // read data returns to zero without a read
  rdata_idle_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    !RD
    |=> RDATA == 8'h00)
    else $error("read data left standing");

  // unmapped reads return zero
  unmapped_read_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (RD && ADDR[4])
    |=> RDATA == 8'h00)
    else $error("unmapped read not zero");

  // (RQ5) status bits above pending read zero
  status_upper_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (RD && !ADDR[4] && ADDR[2:0] == OFS_STATUS)
    |=> RDATA[7:2] == 6'h00)
    else $error("status upper bits set");

  // (RQ20) unmapped writes leave option and limit registers unchanged
  unmapped_write_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    (WR && ADDR[4])
    |=> $stable(option[0]) && $stable(option[1]) && $stable(io_limit[0]) && $stable(io_limit[1]))
    else $error("unmapped write landed");

  // (RQ21) line stays low without a routed request
  irq_low_a: assert property (@(posedge MCLK) disable iff (!RST_N)
    ((pending & routed) == 2'b00 && (FUNC_EVENT & routed) == 2'b00 && !WR)
    |=> !IREQ)
    else $error("line raised without request");
endmodule : mfc_cfg_bank
